//--- verilog/dcsw_pkg.sv
// package: field positions, codes and reset values of the drive command and state words
package dcsw_pkg;

  // ==========================================
  // widths
  localparam int WORD_W = 16;
  localparam int REF_W = 16;
  localparam int SUM_W = 18;
  localparam int MODE_W = 2;
  localparam int CODE_W = 8;

  // ==========================================
  // command word bit positions
  localparam int CW_PRESET_LSB = 0;
  localparam int CW_PRESET_MSB = 1;
  localparam int CW_DC_BRAKE = 2;
  localparam int CW_COAST = 3;
  localparam int CW_QUICK_STOP = 4;
  localparam int CW_HOLD = 5;
  localparam int CW_RAMP_STOP = 6;
  localparam int CW_RESET = 7;
  localparam int CW_JOG = 8;
  localparam int CW_RAMP_SEL = 9;
  localparam int CW_VALID = 10;
  localparam int CW_RELAY1 = 11;
  localparam int CW_RELAY4 = 12;
  localparam int CW_SETUP_LSB = 13;
  localparam int CW_SETUP_MSB = 14;
  localparam int CW_REVERSE = 15;

  // ==========================================
  // state word bit positions
  localparam int SW_CTRL_READY = 0;
  localparam int SW_DRIVE_READY = 1;
  localparam int SW_ENABLE = 2;
  localparam int SW_TRIP = 3;
  localparam int SW_UNUSED = 5;
  localparam int SW_TRIP_LOCK = 6;

  // ==========================================
  // reset values and setting codes
  localparam logic [WORD_W-1:0] CMD_WORD_RESET = 16'h0000;
  localparam logic [WORD_W-1:0] STATE_WORD_RESET = 16'h0000;
  localparam logic [REF_W-1:0] SPEED_RESET = 16'h0000;
  localparam logic [REF_W-1:0] SPEED_STEP = 16'h0001;
  localparam logic [REF_W-1:0] SPEED_MAX = 16'hFFFF;
  localparam logic [SUM_W-1:0] SUM_RESET = 18'h0_0000;
  localparam logic [MODE_W-1:0] MODE_OPEN_LOOP = 2'h0;
  localparam logic [MODE_W-1:0] MODE_CLOSED_LOOP = 2'h3;
  localparam logic [CODE_W-1:0] RELAY1_CODE = 8'h24;
  localparam logic [CODE_W-1:0] RELAY4_CODE = 8'h25;
  localparam logic [CODE_W-1:0] MULTI_SETUP_CODE = 8'h09;

  // ==========================================
  // motor handling states, gray along run-ramp-brake-coast
  typedef enum logic [1:0] {
    MODE_RUN = 2'h0,
    MODE_RAMP = 2'h1,
    MODE_BRAKE = 2'h3,
    MODE_COAST = 2'h2
  } motor_mode_t;

endpackage : dcsw_pkg

//--- verilog/rise_pulse.sv
// rise_pulse: one-cycle pulse on a 0-to-1 change between sampled levels
`timescale 1ns/1ps
module rise_pulse (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_sample,
  input wire logic i_level,
  output logic o_pulse
);

  logic last;

  // ==========================================
  // edge detect on accepted samples only
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      last <= 1'b0;
      o_pulse <= 1'b0;
    end else begin
      o_pulse <= i_sample & i_level & ~last;
      if (i_sample) begin
        last <= i_level;
      end
    end
  end

  // ==========================================
  // checks
  sequence s_rise;
    i_sample && i_level && !last;
  endsequence

  a_edge_fires: assert property (@(posedge i_clk) disable iff (i_rst)
    s_rise |=> o_pulse) else $error("rising reset bit gave no pulse");
  a_level_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_sample && last) |=> !o_pulse) else $error("steady reset level pulsed");

endmodule : rise_pulse

//--- verilog/drive_control_status_word.sv
// drive_control_status_word: command word decode and state word assembly
`timescale 1ns/1ps
module drive_control_status_word (
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic I_CMD_WRITE,
  input wire logic [dcsw_pkg::WORD_W-1:0] I_CMD_WORD,
  input wire logic [dcsw_pkg::MODE_W-1:0] I_CONFIG_MODE,
  input wire logic [dcsw_pkg::REF_W-1:0] I_BUS_REF,
  input wire logic [dcsw_pkg::REF_W-1:0] I_EXT_REF,
  input wire logic [dcsw_pkg::REF_W-1:0] I_PRESET0,
  input wire logic [dcsw_pkg::REF_W-1:0] I_PRESET1,
  input wire logic [dcsw_pkg::REF_W-1:0] I_PRESET2,
  input wire logic [dcsw_pkg::REF_W-1:0] I_PRESET3,
  input wire logic [dcsw_pkg::REF_W-1:0] I_JOG_SPEED,
  input wire logic [dcsw_pkg::CODE_W-1:0] I_RELAY1_FUNC,
  input wire logic [dcsw_pkg::CODE_W-1:0] I_RELAY4_FUNC,
  input wire logic [dcsw_pkg::CODE_W-1:0] I_ACTIVE_SETUP,
  input wire logic I_REVERSE_LOCK,
  input wire logic I_DI_SPEED_UP,
  input wire logic I_DI_SPEED_DOWN,
  input wire logic I_DI_DC_BRAKE,
  input wire logic I_DI_COAST,
  input wire logic I_DI_RESET_COAST,
  input wire logic I_TRIPPED,
  input wire logic I_TRIP_LOCKED,
  input wire logic I_CONTROLS_READY,
  output logic [dcsw_pkg::WORD_W-1:0] O_CMD_WORD,
  output logic [dcsw_pkg::WORD_W-1:0] O_STATE_WORD,
  output logic O_OPEN_LOOP,
  output logic O_CLOSED_LOOP,
  output logic [dcsw_pkg::SUM_W-1:0] O_TOTAL_REF,
  output logic [dcsw_pkg::REF_W-1:0] O_SPEED_CMD,
  output logic [1:0] O_PRESET_INDEX,
  output logic O_OUTPUT_ENABLE,
  output logic O_DC_BRAKE,
  output logic O_QUICK_STOP,
  output logic O_RAMP_STOP,
  output logic O_FREEZE,
  output logic O_FAULT_RESET,
  output logic O_JOG,
  output logic O_RAMP_SEL,
  output logic O_RELAY1,
  output logic O_RELAY4,
  output logic [1:0] O_SETUP_SEL,
  output logic O_SETUP_APPLY,
  output logic O_REVERSE
);
  import dcsw_pkg::*;

  // ==========================================
  // command word register
  logic [WORD_W-1:0] cmd;
  wire accept = I_CMD_WRITE & I_CMD_WORD[CW_VALID];

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      cmd <= CMD_WORD_RESET;
    end else if (accept) begin
      cmd <= I_CMD_WORD;
    end
  end

  assign O_CMD_WORD = cmd;

  // ==========================================
  // fault reset on rising edge of the reset bit
  rise_pulse u_reset_edge (
    .i_clk(I_MCLK),
    .i_rst(I_RST),
    .i_sample(accept),
    .i_level(I_CMD_WORD[CW_RESET]),
    .o_pulse(O_FAULT_RESET)
  );

  // ==========================================
  // reference handling
  wire [1:0] preset_index = cmd[CW_PRESET_MSB:CW_PRESET_LSB];
  wire [REF_W-1:0] preset_ref =
    (preset_index == 2'h0) ? I_PRESET0 :
    (preset_index == 2'h1) ? I_PRESET1 :
    (preset_index == 2'h2) ? I_PRESET2 : I_PRESET3;
  wire [SUM_W-1:0] total_sum =
    SUM_W'(I_BUS_REF) + SUM_W'(I_EXT_REF) + SUM_W'(preset_ref);
  wire sum_over = |total_sum[SUM_W-1:REF_W];
  wire [REF_W-1:0] sat_ref = sum_over ? SPEED_MAX : total_sum[REF_W-1:0];

  assign O_PRESET_INDEX = preset_index;

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_TOTAL_REF <= SUM_RESET;
      O_OPEN_LOOP <= 1'b1;
      O_CLOSED_LOOP <= 1'b0;
    end else begin
      O_TOTAL_REF <= total_sum;
      O_OPEN_LOOP <= (I_CONFIG_MODE == MODE_OPEN_LOOP);
      O_CLOSED_LOOP <= (I_CONFIG_MODE == MODE_CLOSED_LOOP);
    end
  end

  // ==========================================
  // output frequency: jog, freeze with speed up/down, or reference
  wire frozen = ~cmd[CW_HOLD];
  wire jog = cmd[CW_JOG];
  wire step_up = I_DI_SPEED_UP & ~I_DI_SPEED_DOWN & (O_SPEED_CMD != SPEED_MAX);
  wire step_dn = I_DI_SPEED_DOWN & ~I_DI_SPEED_UP & (O_SPEED_CMD != SPEED_RESET);
  wire [REF_W-1:0] held_speed =
    step_up ? O_SPEED_CMD + SPEED_STEP :
    step_dn ? O_SPEED_CMD - SPEED_STEP : O_SPEED_CMD;
  wire [REF_W-1:0] next_speed =
    jog ? I_JOG_SPEED : frozen ? held_speed : sat_ref;

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_SPEED_CMD <= SPEED_RESET;
    end else begin
      O_SPEED_CMD <= next_speed;
    end
  end

  assign O_FREEZE = frozen;
  assign O_JOG = jog;
  assign O_RAMP_SEL = cmd[CW_RAMP_SEL];

  // ==========================================
  // stop handling, coast over brake over ramp
  wire coast_req = ~cmd[CW_COAST] | I_DI_COAST | I_DI_RESET_COAST | I_TRIPPED;
  wire brake_req = ~cmd[CW_DC_BRAKE] | I_DI_DC_BRAKE;
  wire quick_req = ~frozen & ~cmd[CW_QUICK_STOP];
  wire ramp_req = ~frozen & ~cmd[CW_RAMP_STOP];
  motor_mode_t mode;
  motor_mode_t next_mode;

  assign next_mode = coast_req ? MODE_COAST :
                     brake_req ? MODE_BRAKE :
                     (quick_req | ramp_req) ? MODE_RAMP : MODE_RUN;

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      mode <= MODE_COAST;
    end else begin
      mode <= next_mode;
    end
  end

  // ==========================================
  // latched stop kind for the ramp state
  logic quick_kind;

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      quick_kind <= 1'b0;
    end else begin
      quick_kind <= quick_req;
    end
  end

  always_comb begin
    O_OUTPUT_ENABLE = 1'b1;
    O_DC_BRAKE = 1'b0;
    O_QUICK_STOP = 1'b0;
    O_RAMP_STOP = 1'b0;
    case (mode)
      MODE_RUN: begin
        O_OUTPUT_ENABLE = 1'b1;
      end
      MODE_RAMP: begin
        O_QUICK_STOP = quick_kind;
        O_RAMP_STOP = ~quick_kind;
      end
      MODE_BRAKE: begin
        O_DC_BRAKE = 1'b1;
      end
      MODE_COAST: begin
        O_OUTPUT_ENABLE = 1'b0;
      end
      default: begin
        O_OUTPUT_ENABLE = 1'b0;
      end
    endcase
  end

  // ==========================================
  // relays, set-up and direction
  wire [1:0] relay_bit = {cmd[CW_RELAY4], cmd[CW_RELAY1]};
  wire [CODE_W-1:0] relay_func [2];
  logic [1:0] relay_on;

  assign relay_func[0] = I_RELAY1_FUNC;
  assign relay_func[1] = I_RELAY4_FUNC;

  for (genvar g = 0; g < 2; g++) begin : g_relay
    wire [CODE_W-1:0] code = (g == 0) ? RELAY1_CODE : RELAY4_CODE;
    always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
        relay_on[g] <= 1'b0;
      end else begin
        relay_on[g] <= relay_bit[g] & (relay_func[g] == code);
      end
    end
  end

  assign O_RELAY1 = relay_on[0];
  assign O_RELAY4 = relay_on[1];

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_SETUP_SEL <= 2'h0;
      O_SETUP_APPLY <= 1'b0;
      O_REVERSE <= 1'b0;
    end else begin
      O_SETUP_SEL <= cmd[CW_SETUP_MSB:CW_SETUP_LSB];
      O_SETUP_APPLY <= (I_ACTIVE_SETUP == MULTI_SETUP_CODE);
      O_REVERSE <= cmd[CW_REVERSE] & ~I_REVERSE_LOCK;
    end
  end

  // ==========================================
  // state word
  logic [WORD_W-1:0] next_state_word;

  always_comb begin
    next_state_word = STATE_WORD_RESET;
    next_state_word[SW_CTRL_READY] = I_CONTROLS_READY & ~I_TRIPPED;
    next_state_word[SW_DRIVE_READY] = I_CONTROLS_READY & ~I_TRIPPED;
    next_state_word[SW_ENABLE] = ~coast_req;
    next_state_word[SW_TRIP] = I_TRIPPED & ~I_TRIP_LOCKED;
    next_state_word[SW_TRIP_LOCK] = I_TRIP_LOCKED;
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_STATE_WORD <= STATE_WORD_RESET;
    end else begin
      O_STATE_WORD <= next_state_word;
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_RST);

  wire no_stop_in = !I_DI_COAST && !I_DI_RESET_COAST && !I_DI_DC_BRAKE && !I_TRIPPED;

  sequence s_accept;
    I_CMD_WRITE && I_CMD_WORD[CW_VALID];
  endsequence

  sequence s_reject;
    !(I_CMD_WRITE && I_CMD_WORD[CW_VALID]);
  endsequence

  sequence s_frozen_run;
    frozen && cmd[CW_COAST] && cmd[CW_DC_BRAKE] && no_stop_in;
  endsequence

  a_word_taken: assert property (
    s_accept |=> O_CMD_WORD == $past(I_CMD_WORD)) else $error("valid word not taken");
  a_word_ignored: assert property (
    s_reject |=> $stable(O_CMD_WORD)) else $error("invalid word changed state");
  a_loop_select: assert property (
    I_CONFIG_MODE == MODE_CLOSED_LOOP |=> O_CLOSED_LOOP && !O_OPEN_LOOP)
    else $error("closed loop not selected");
  a_total_ref: assert property (
    1'b1 |=> O_TOTAL_REF == 18'($past(I_BUS_REF)) + 18'($past(I_EXT_REF))
      + 18'($past(O_PRESET_INDEX) == 2'h0 ? $past(I_PRESET0) :
            $past(O_PRESET_INDEX) == 2'h1 ? $past(I_PRESET1) :
            $past(O_PRESET_INDEX) == 2'h2 ? $past(I_PRESET2) : $past(I_PRESET3)))
    else $error("total reference wrong");
  a_coast_first: assert property (
    !cmd[CW_COAST] |=> mode == MODE_COAST && !O_OUTPUT_ENABLE)
    else $error("coast bit did not release motor");
  a_dc_brake: assert property (
    cmd[CW_COAST] && !cmd[CW_DC_BRAKE] && no_stop_in |=> O_DC_BRAKE)
    else $error("dc brake not applied");
  a_quick_stop: assert property (
    cmd[CW_COAST] && cmd[CW_DC_BRAKE] && no_stop_in && !frozen
      && !cmd[CW_QUICK_STOP] |=> O_QUICK_STOP && !O_RAMP_STOP)
    else $error("quick stop not applied");
  a_ramp_stop: assert property (
    cmd[CW_COAST] && cmd[CW_DC_BRAKE] && no_stop_in && !frozen && cmd[CW_QUICK_STOP]
      && !cmd[CW_RAMP_STOP] |=> O_RAMP_STOP)
    else $error("ramp stop not applied");
  a_frozen_runs: assert property (
    s_frozen_run |=> mode == MODE_RUN) else $error("frozen drive stopped by ramp bit");
  a_freeze_hold: assert property (
    frozen && !jog && !I_DI_SPEED_UP && !I_DI_SPEED_DOWN |=> $stable(O_SPEED_CMD))
    else $error("frozen frequency moved");
  a_freeze_step: assert property (
    frozen && !jog && I_DI_SPEED_UP && !I_DI_SPEED_DOWN && O_SPEED_CMD != SPEED_MAX
      |=> O_SPEED_CMD == $past(O_SPEED_CMD) + SPEED_STEP)
    else $error("frozen speed did not step up");
  a_jog_speed: assert property (
    jog |=> O_SPEED_CMD == $past(I_JOG_SPEED)) else $error("jog speed not used");
  a_relay1_gate: assert property (
    I_RELAY1_FUNC != RELAY1_CODE |=> !O_RELAY1) else $error("relay 1 driven unselected");
  a_relay4_gate: assert property (
    I_RELAY4_FUNC == RELAY4_CODE && cmd[CW_RELAY4] |=> O_RELAY4)
    else $error("relay 4 not driven");
  a_setup_gate: assert property (
    I_ACTIVE_SETUP != MULTI_SETUP_CODE |=> !O_SETUP_APPLY) else $error("set-up applied");
  a_reverse_lock: assert property (
    I_REVERSE_LOCK |=> !O_REVERSE) else $error("reverse despite lock");
  a_trip_bits: assert property (
    I_TRIPPED && !I_TRIP_LOCKED |=> !O_STATE_WORD[SW_CTRL_READY] && O_STATE_WORD[SW_TRIP])
    else $error("trip not reported");
  a_enable_bit: assert property (
    !cmd[CW_COAST] |=> !O_STATE_WORD[SW_ENABLE]) else $error("enable shown while coasting");
  a_lock_bit: assert property (
    I_TRIP_LOCKED |=> O_STATE_WORD[SW_TRIP_LOCK] && !O_STATE_WORD[SW_TRIP])
    else $error("trip lock not reported");
  a_unused_bit: assert property (
    1'b1 |-> !O_STATE_WORD[SW_UNUSED] && O_STATE_WORD[15:7] == 9'h000)
    else $error("unused state bits set");

endmodule : drive_control_status_word

//--- dv/net_ctrl_node.sv
// net_ctrl_node: model of the network controller node that sends command words
`timescale 1ns/1ps
module net_ctrl_node (
  input wire logic i_clk,
  output logic o_cmd_write,
  output logic [dcsw_pkg::WORD_W-1:0] o_cmd_word,
  output logic [dcsw_pkg::REF_W-1:0] o_bus_ref
);
  import dcsw_pkg::*;
  initial begin
    o_cmd_write = 1'b0;
    o_cmd_word = 16'h0000;
    o_bus_ref = 16'h0000;
  end
  // ==========================================
  // one write per call, set after an edge and held across the sampling edge
  task automatic send(input logic [WORD_W-1:0] word, input logic [REF_W-1:0] pct);
    @(posedge i_clk);
    #1;
    o_cmd_write = 1'b1;
    o_cmd_word = word;
    o_bus_ref = pct; // reference sent as speed percent
    @(posedge i_clk);
    #1;
    o_cmd_write = 1'b0;
    o_cmd_word = ~word; // released word lines do not keep the last value
  endtask : send
endmodule : net_ctrl_node

//--- dv/drive_control_status_word_tb.sv
// drive_control_status_word_tb: random and corner tests of command decode and state word
`timescale 1ns/1ps
module drive_control_status_word_tb;
  import dcsw_pkg::*;
  logic mclk, rst, wr, up, dn, dbrk, dcst, drc, trip, lock, rdy, rlk, cst, brk, frz;
  logic [15:0] cw, bref, eref, jog, w, o_cw, o_sw, o_spd;
  logic [15:0] pre [4];
  logic [7:0] r1f, r4f, stp;
  logic [1:0] mode, o_pi, o_ss;
  logic [17:0] o_tot, tot;
  logic o_ol, o_cl, o_en, o_db, o_qs, o_rs, o_fz, o_fr, o_jg, o_ra, o_r1, o_r4, o_sa, o_rv;
  int errors, tests_run, cycles, pulses, seed, p0;

  drive_control_status_word DUT (
    .I_MCLK(mclk), .I_RST(rst), .I_CMD_WRITE(wr), .I_CMD_WORD(cw), .I_CONFIG_MODE(mode),
    .I_BUS_REF(bref), .I_EXT_REF(eref), .I_PRESET0(pre[0]), .I_PRESET1(pre[1]),
    .I_PRESET2(pre[2]), .I_PRESET3(pre[3]), .I_JOG_SPEED(jog), .I_RELAY1_FUNC(r1f),
    .I_RELAY4_FUNC(r4f), .I_ACTIVE_SETUP(stp), .I_REVERSE_LOCK(rlk), .I_DI_SPEED_UP(up),
    .I_DI_SPEED_DOWN(dn), .I_DI_DC_BRAKE(dbrk), .I_DI_COAST(dcst), .I_DI_RESET_COAST(drc),
    .I_TRIPPED(trip), .I_TRIP_LOCKED(lock), .I_CONTROLS_READY(rdy), .O_CMD_WORD(o_cw),
    .O_STATE_WORD(o_sw), .O_OPEN_LOOP(o_ol), .O_CLOSED_LOOP(o_cl), .O_TOTAL_REF(o_tot),
    .O_SPEED_CMD(o_spd), .O_PRESET_INDEX(o_pi), .O_OUTPUT_ENABLE(o_en), .O_DC_BRAKE(o_db),
    .O_QUICK_STOP(o_qs), .O_RAMP_STOP(o_rs), .O_FREEZE(o_fz), .O_FAULT_RESET(o_fr),
    .O_JOG(o_jg), .O_RAMP_SEL(o_ra), .O_RELAY1(o_r1), .O_RELAY4(o_r4), .O_SETUP_SEL(o_ss),
    .O_SETUP_APPLY(o_sa), .O_REVERSE(o_rv));
  net_ctrl_node node (.i_clk(mclk), .o_cmd_write(wr), .o_cmd_word(cw), .o_bus_ref(bref));

  // ==========================================
  // clock, pulse count and timeout
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (o_fr === 1'b1) pulses++;
    if (cycles == 5000) begin
      errors++;
      end_of_test();
    end
  end

  // ==========================================
  // checking and expectations
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  function automatic logic [15:0] exp_state();
    logic ok;
    ok = rdy & ~trip;
    return {9'h000, lock, 2'h0, trip & ~lock, ~cst, ok, ok};
  endfunction : exp_state
  task automatic go(input logic [15:0] word, input logic [15:0] pct);
    node.send(word, pct);
    repeat (3) @(posedge mclk);
    #1;
  endtask : go
  task automatic check_all(input logic [15:0] v);
    cst = ~v[3] | dcst | drc | trip;
    brk = ~cst & (~v[2] | dbrk);
    frz = ~v[5];
    tot = 18'(bref) + 18'(eref) + 18'(pre[v[1:0]]);
    check("cmd", o_cw, v);
    check("preset", o_pi, v[1:0]);
    check("total", o_tot, tot);
    check("loop", {o_ol, o_cl}, {mode == MODE_OPEN_LOOP, mode == MODE_CLOSED_LOOP});
    check("enable", o_en, !cst);
    check("brake", o_db, brk);
    check("qstop", o_qs, !cst && !brk && !frz && !v[4]);
    check("rstop", o_rs, ~cst & ~brk & ~frz & v[4] & ~v[6]);
    check("freeze", o_fz, frz);
    check("jog", o_jg, v[8]);
    check("ramp", o_ra, v[9]);
    check("relay1", o_r1, v[11] & (r1f == RELAY1_CODE));
    check("relay4", o_r4, v[12] & (r4f == RELAY4_CODE));
    check("setup", {o_sa, o_ss}, {stp == MULTI_SETUP_CODE, v[14:13]});
    check("reverse", o_rv, v[15] & ~rlk);
    check("state", o_sw, exp_state());
    if (v[8]) begin
      check("speed", o_spd, jog);
    end else if (!frz) begin
      check("speed", o_spd, tot > 18'h0_FFFF ? 16'hFFFF : tot[15:0]);
    end
  endtask : check_all
  task automatic rand_cfg();
    eref = 16'($random(seed));
    foreach (pre[i]) pre[i] = 16'($random(seed));
    jog = 16'($random(seed));
    r1f = $random(seed) & 1 ? RELAY1_CODE : 8'($random(seed));
    r4f = $random(seed) & 1 ? RELAY4_CODE : 8'($random(seed));
    stp = $random(seed) & 1 ? MULTI_SETUP_CODE : 8'h08;
    {dbrk, dcst, drc, trip} = 4'($random(seed) & $random(seed) & $random(seed));
    {lock, rdy, rlk, mode} = 5'($random(seed));
  endtask : rand_cfg

  // ==========================================
  // main sequence
  initial begin
    seed = 98610;
    rst = 1'b1;
    {up, dn, dbrk, dcst, drc, trip, lock, rlk} = 8'h00;
    rdy = 1'b1;
    mode = MODE_OPEN_LOOP;
    eref = 16'h0000;
    foreach (pre[i]) pre[i] = 16'h0000;
    jog = 16'h0000;
    r1f = RELAY1_CODE;
    r4f = RELAY4_CODE;
    stp = MULTI_SETUP_CODE;
    repeat (2) @(posedge mclk);
    #1;
    check("rst cmd", o_cw, CMD_WORD_RESET);
    check("rst enable", {o_en, o_ol}, 2'h1);
    check("rst state", o_sw, STATE_WORD_RESET);
    rst = 1'b0;
    go(16'h044C, 16'h0010);
    p0 = pulses;
    go(16'h04CC, 16'h0010);
    check("reset pulse", pulses - p0, 1);
    go(16'h04CC, 16'h0010);
    go(16'h004C, 16'h0010);
    check("ignored", o_cw, 16'h04CC);
    go(16'h04CC, 16'h0010);
    check("steady", pulses - p0, 1);
    go(16'h047C, 16'h0100);
    check_all(16'h047C);
    go(16'h045C, 16'h0100);
    go(16'h040C, 16'h0300);
    check("frozen", o_spd, 16'h0100);
    check_all(16'h040C);
    up = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    up = 1'b0;
    dn = 1'b1;
    @(posedge mclk);
    #1;
    dn = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    check("speed step", o_spd, 16'h0102);
    dbrk = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    check("frozen brake", o_db, 1'b1);
    for (int n = 0; n < 60; n++) begin
      @(posedge mclk);
      #1;
      rand_cfg();
      w = 16'($random(seed)) | 16'h0400;
      go(w, 16'($random(seed)));
      check_all(w);
    end
    end_of_test();
  end
endmodule : drive_control_status_word_tb
